// *** design/pcpd_pkg.sv ***
// Constants and types shared by the sleep hold logic
package pcpd_pkg;

  // ****************************************
  // Pin counts and sleep pin positions
  // ****************************************
  localparam int DED_W        = 4;
  localparam int IO_W         = 8;
  localparam int SLEEP_PIN_A  = 2;
  localparam int SLEEP_PIN_B  = 6;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_PERIOD_PS  = 5000;
  localparam int IGNORE_FAST_NS = 25;
  localparam int IGNORE_SLOW_NS = 30;
  // Longest time, rounded down; the faster grade bound covers both grades
  localparam int IGNORE_CYC     = (IGNORE_FAST_NS * 1000) / CLK_PERIOD_PS;
  localparam int WAKE_US        = 1;
  // Longest time, rounded down
  localparam int WAKE_CYC       = (WAKE_US * 1000000) / CLK_PERIOD_PS;
  localparam int WAKE_CW        = 8;
  localparam logic [WAKE_CW-1:0] WAKE_LAST = WAKE_CW'(WAKE_CYC - 1);

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic RST_PAD_O   = 1'h0;
  localparam logic RST_PAD_OE_N = 1'h1;
  localparam logic RST_KEEP_OE_N = 1'h1;
  localparam logic RST_ARRAY_IN = 1'h0;

  // ****************************************
  // States
  // ****************************************
  typedef enum logic [1:0] {
    PCPD_RUN,
    PCPD_SLEEP,
    PCPD_WAKE
  } pcpd_state_e;

endpackage

// *** design/pcpd_sync.sv ***
// Two flip-flop synchroniser for a group of pin levels
`timescale 1ns/100ps
module pcpd_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta_reg;

  always_ff @(posedge clk) begin
    if (rst) begin
      meta_reg <= '0;
      q        <= '0;
    end else begin
      meta_reg <= d;
      q        <= meta_reg;
    end
  end

endmodule

// *** design/pcpd_pin_cell.sv ***
// One bidirectional pin with its output hold, input hold and keeper
`timescale 1ns/100ps
module pcpd_pin_cell
  import pcpd_pkg::*;
(
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic freeze,
  input  wire logic is_sleep,
  input  wire logic core_out,
  input  wire logic core_oe,
  input  wire logic pin_in,
  output logic      pad_o,
  output logic      pad_oe_n,
  output logic      keep_o,
  output logic      keep_oe_n,
  output logic      array_in
);

  // ****************************************
  // Output driver, held while frozen
  // ****************************************
  always_ff @(posedge clk) begin
    if (rst) begin
      pad_o    <= RST_PAD_O;
      pad_oe_n <= RST_PAD_OE_N;
    end else if (!freeze) begin
      pad_o    <= core_out;
      pad_oe_n <= ~(core_oe & ~is_sleep);
    end
  end

  // ****************************************
  // Input to the logic array, held while frozen
  // ****************************************
  always_ff @(posedge clk) begin
    if (rst) begin
      array_in <= RST_ARRAY_IN;
    end else if (!freeze) begin
      array_in <= pin_in & ~is_sleep;
    end
  end

  // ****************************************
  // Keeper: drives the last seen level onto an undriven pin other than the sleep pin while frozen
  // ****************************************
  always_ff @(posedge clk) begin
    if (rst) begin
      keep_o    <= RST_PAD_O;
      keep_oe_n <= RST_KEEP_OE_N;
    end else if (!freeze) begin
      keep_o    <= pin_in;
      keep_oe_n <= 1'h1;
    end else begin
      keep_oe_n <= ~pad_oe_n | is_sleep;
    end
  end

endmodule

// *** design/pcpd_top.sv ***
// Pin-controlled sleep hold logic: freezes state, blocks inputs, keeps pins
// ****************************************
// How it works
// - Sleep feature chosen at configuration; only then a pin acts as sleep request.
// - With the feature on, sleep is entered while the sleep pin is high.
// - Entering sleep freezes all state and output data; outputs stay valid.
// - Outputs that were high-impedance at sleep onset stay high-impedance.
// - During sleep every input except the sleep pin is ignored.
// - Input and pin hold keepers stay active in sleep so no pin but the sleep pin can float.
// - The chosen sleep pin is never an input to the logic array.
// - The sleep pin's macrocell keeps its feedback available to the design.
// - Inputs, enables and clocks become don't-care within 25 ns of sleep.
// - Everything becomes valid 203 cycles (1015 ns) after the sleep pin falls: 200 wake counts plus synchroniser and output registers.
// - Either of two bidirectional pins may be chosen as the sleep pin.
// ****************************************
`timescale 1ns/100ps
module pcpd_top
  import pcpd_pkg::*;
(
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             cfg_sleep_en,
  input  wire logic             cfg_sleep_sel,
  input  wire logic [DED_W-1:0] ded_in,
  input  wire logic [IO_W-1:0]  io_i,
  input  wire logic [IO_W-1:0]  core_out,
  input  wire logic [IO_W-1:0]  core_oe,
  output logic      [IO_W-1:0]  io_o,
  output logic      [IO_W-1:0]  io_oe_n,
  output logic      [IO_W-1:0]  io_keep_o,
  output logic      [IO_W-1:0]  io_keep_oe_n,
  output logic      [DED_W-1:0] ded_keep_o,
  output logic      [DED_W-1:0] ded_keep_oe_n,
  output logic      [DED_W-1:0] array_ded,
  output logic      [IO_W-1:0]  array_io,
  output logic      [IO_W-1:0]  feedback,
  output logic                  core_run,
  output logic                  asleep,
  output logic                  wake_valid
);

  // ****************************************
  // Configuration and pin synchronisers
  // ****************************************
  logic              cfg_en_reg;
  logic              cfg_sel_reg;
  logic [IO_W-1:0]   sleep_mask_reg;
  logic [IO_W-1:0]   io_sync;
  logic [DED_W-1:0]  ded_sync;
  logic              sleep_request_pin;
  pcpd_state_e       state_reg;
  pcpd_state_e       state_next;
  logic [WAKE_CW-1:0] wake_cnt_reg;
  logic [WAKE_CW-1:0] wake_cnt_next;
  logic              hold;

  // Straps are taken while reset is held and kept afterwards
  always_ff @(posedge clk) begin
    if (rst) begin
      cfg_en_reg  <= cfg_sleep_en;
      cfg_sel_reg <= cfg_sleep_sel;
    end
  end

  // Mask follows the straps during reset too, so pin cells see it at the first edge after release
  always_ff @(posedge clk) begin
    if (cfg_en_reg) begin
      sleep_mask_reg <= cfg_sel_reg ? IO_W'(1 << SLEEP_PIN_B) : IO_W'(1 << SLEEP_PIN_A);
    end else begin
      sleep_mask_reg <= '0;
    end
  end

  pcpd_sync #(
    .W (IO_W)
  ) u_io_sync (
    .clk (clk),
    .rst (rst),
    .d   (io_i),
    .q   (io_sync)
  );

  pcpd_sync #(
    .W (DED_W)
  ) u_ded_sync (
    .clk (clk),
    .rst (rst),
    .d   (ded_in),
    .q   (ded_sync)
  );

  // Sleep request seen only when the feature is configured
  assign sleep_request_pin = |(io_sync & sleep_mask_reg);

  // ****************************************
  // Sleep sequencer
  // ****************************************
  always_comb begin
    state_next    = state_reg;
    wake_cnt_next = wake_cnt_reg;
    case (state_reg)
      PCPD_RUN: begin
        if (sleep_request_pin) begin
          state_next = PCPD_SLEEP;
        end
      end
      PCPD_SLEEP: begin
        if (!sleep_request_pin) begin
          state_next    = PCPD_WAKE;
          wake_cnt_next = '0;
        end
      end
      PCPD_WAKE: begin
        if (sleep_request_pin) begin
          state_next = PCPD_SLEEP;
        end else if (wake_cnt_reg == WAKE_LAST) begin
          state_next = PCPD_RUN;
        end else begin
          wake_cnt_next = wake_cnt_reg + WAKE_CW'(1);
        end
      end
      default: begin
        state_next = PCPD_RUN;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_reg    <= PCPD_RUN;
      wake_cnt_reg <= '0;
    end else begin
      state_reg    <= state_next;
      wake_cnt_reg <= wake_cnt_next;
    end
  end

  // Freeze starts on the same edge the request is seen and lasts until wake ends
  assign hold = (state_next != PCPD_RUN);

  always_ff @(posedge clk) begin
    if (rst) begin
      core_run   <= 1'h1;
      asleep     <= 1'h0;
      wake_valid <= 1'h0;
    end else begin
      core_run   <= ~hold;
      asleep     <= (state_next == PCPD_SLEEP);
      wake_valid <= (state_reg == PCPD_WAKE) && (state_next == PCPD_RUN);
    end
  end

  // ****************************************
  // Pins
  // ****************************************
  for (genvar i = 0; i < IO_W; i++) begin : g_pin
    pcpd_pin_cell u_cell (
      .clk       (clk),
      .rst       (rst),
      .freeze    (hold),
      .is_sleep  (sleep_mask_reg[i]),
      .core_out  (core_out[i]),
      .core_oe   (core_oe[i]),
      .pin_in    (io_sync[i]),
      .pad_o     (io_o[i]),
      .pad_oe_n  (io_oe_n[i]),
      .keep_o    (io_keep_o[i]),
      .keep_oe_n (io_keep_oe_n[i]),
      .array_in  (array_io[i])
    );
  end

  // ****************************************
  // Dedicated inputs and their keepers
  // ****************************************
  always_ff @(posedge clk) begin
    if (rst) begin
      array_ded <= '0;
    end else if (!hold) begin
      array_ded <= ded_sync;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      ded_keep_o    <= '0;
      ded_keep_oe_n <= '1;
    end else if (!hold) begin
      ded_keep_o    <= ded_sync;
      ded_keep_oe_n <= '1;
    end else begin
      ded_keep_oe_n <= '0;
    end
  end

  // Buried feedback of every macrocell, the sleep pin's included
  always_ff @(posedge clk) begin
    if (rst) begin
      feedback <= '0;
    end else if (!hold) begin
      feedback <= core_out;
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  localparam int A_IGN = IGNORE_CYC;
  localparam int A_WAKE = WAKE_CYC + 1;

  sequence frozen_two_s;
    !core_run ##1 !core_run;
  endsequence

  sequence pin_high_s;
    sleep_request_pin && cfg_en_reg;
  endsequence

  sleep_disabled_a: assert property (@(posedge clk) disable iff (rst)
    !cfg_en_reg |-> (core_run && !asleep))
    else $error("sleep entered with feature off");

  sleep_enter_a: assert property (@(posedge clk) disable iff (rst)
    $rose(sleep_request_pin) |=> (asleep && !core_run))
    else $error("sleep not entered after request");

  enter_latency_a: assert property (@(posedge clk) disable iff (rst)
    ($rose(io_i[SLEEP_PIN_A]) && cfg_en_reg && !cfg_sel_reg) ##1 io_i[SLEEP_PIN_A] [*3]
      |-> ##[0:A_IGN] !core_run)
    else $error("inputs still taken too long after sleep request");

  out_hold_a: assert property (@(posedge clk) disable iff (rst)
    frozen_two_s |-> ($stable(io_o) && $stable(feedback)))
    else $error("output data changed in sleep");

  hiz_hold_a: assert property (@(posedge clk) disable iff (rst)
    frozen_two_s |-> $stable(io_oe_n))
    else $error("output enable changed in sleep");

  input_block_a: assert property (@(posedge clk) disable iff (rst)
    frozen_two_s |-> ($stable(array_io) && $stable(array_ded)))
    else $error("input reached array in sleep");

  keeper_on_a: assert property (@(posedge clk) disable iff (rst)
    frozen_two_s |-> (io_keep_oe_n == (~io_oe_n | sleep_mask_reg)) && (ded_keep_oe_n == '0))
    else $error("keeper not active in sleep");

  sleep_pin_a: assert property (@(posedge clk) disable iff (rst)
    ##1 (((array_io & sleep_mask_reg) == '0) && ((io_oe_n & sleep_mask_reg) == sleep_mask_reg)))
    else $error("sleep pin used as array input or driven");

  feedback_a: assert property (@(posedge clk) disable iff (rst)
    (core_run && !hold) |=> (feedback == $past(core_out)))
    else $error("feedback lost");

  wake_early_a: assert property (@(posedge clk) disable iff (rst)
    (asleep ##1 !pin_high_s) |-> (!core_run [*8]))
    else $error("resumed too early");

  wake_bound_a: assert property (@(posedge clk) disable iff (rst)
    ($fell(sleep_request_pin) && state_reg == PCPD_SLEEP)
      |-> ##[1:A_WAKE] (core_run || sleep_request_pin))
    else $error("wake took longer than allowed");

  pin_choice_a: assert property (@(posedge clk) disable iff (rst)
    ##1 (cfg_en_reg |-> ($countones(sleep_mask_reg) == 1)))
    else $error("no single sleep pin chosen");

  resume_a: assert property (@(posedge clk) disable iff (rst)
    $rose(core_run) |-> $past(wake_cnt_reg) == WAKE_LAST)
    else $error("resumed without full wake count");

endmodule

// *** testbench/pcpd_sleep_host.sv ***
// External logic model that drives the sleep request pin
`timescale 1ns/100ps
module pcpd_sleep_host (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic req,
  input  wire logic wake_valid,
  output logic      pin,
  output logic      ready
);
  // ****************************************
  // Pin drive and device usability
  // ****************************************
  always_ff @(posedge clk) begin
    pin <= rst ? 1'h0 : req;
  end
  // Device is not relied on from the pin rise until the wake pulse
  always_ff @(posedge clk) begin
    if (rst) begin
      ready <= 1'h1;
    end else if (req) begin
      ready <= 1'h0;
    end else if (wake_valid) begin
      ready <= 1'h1;
    end
  end
endmodule

// *** testbench/tb.sv ***
// Self-checking bench for the sleep hold logic
`timescale 1ns/100ps
module tb
  import pcpd_pkg::*;
;
  typedef struct {int at; int sel; logic [7:0] exp;} pcpd_note_s;
  pcpd_note_s       notes[$];
  string            nm[10] = '{"io_o", "io_oe_n", "feedback", "array_io", "array_ded", "io_keep_oe_n",
                              "ded_keep_oe_n", "state", "io_keep_o", "ded_keep_o"};
  logic             clk, rst, cfg_sleep_en, cfg_sleep_sel, req, pin, ready;
  logic             core_run, asleep, wake_valid;
  logic [DED_W-1:0] ded_in, ded_keep_o, ded_keep_oe_n, array_ded, dd;
  logic [IO_W-1:0]  io_r, io_i, core_out, core_oe, io_o, io_oe_n, io_keep_o, io_keep_oe_n;
  logic [IO_W-1:0]  array_io, feedback, pmask, m, co, ce, ai, got;
  int               cyc, n_errors, num_checks, seed;

  assign pmask = 8'h1 << (cfg_sleep_sel ? SLEEP_PIN_B : SLEEP_PIN_A);
  assign io_i  = pin ? (io_r | pmask) : (io_r & ~pmask);

  pcpd_top i_dut (.clk, .rst, .cfg_sleep_en, .cfg_sleep_sel, .ded_in, .io_i, .core_out, .core_oe, .io_o,
    .io_oe_n, .io_keep_o, .io_keep_oe_n, .ded_keep_o, .ded_keep_oe_n, .array_ded, .array_io, .feedback,
    .core_run, .asleep, .wake_valid);
  pcpd_sleep_host i_host (.clk, .rst, .req, .wake_valid, .pin, .ready);

  // ****************************************
  // Clock, scoreboard and watchdog
  // ****************************************
  initial begin
    clk = 1'h0;
    forever #2.5 clk = ~clk;
  end

  function automatic logic [7:0] obs(int s);
    case (s)
      0: return io_o;
      1: return io_oe_n;
      2: return feedback;
      3: return array_io;
      4: return {4'h0, array_ded};
      5: return io_keep_oe_n;
      6: return {4'h0, ded_keep_oe_n};
      8: return io_keep_o & ~m;
      9: return {4'h0, ded_keep_o};
      default: return {5'h0, asleep, core_run, wake_valid};
    endcase
  endfunction

  always @(negedge clk) begin
    cyc = cyc + 1;
    for (int i = notes.size() - 1; i >= 0; i--) begin
      if (notes[i].at == cyc) begin
        num_checks++;
        got = obs(notes[i].sel);
        if (got !== notes[i].exp) begin
          n_errors++;
          $display("wrong value %s expected %h seen %h", nm[notes[i].sel], notes[i].exp, got);
        end
        notes.delete(i);
      end
    end
  end

  initial begin
    #20000;
    n_errors++;
    print_verdict();
  end

  // ****************************************
  // Stimulus tasks
  // ****************************************
  task automatic note(int d, int s, logic [7:0] e);
    // Checked on the falling edge after the d-th rising edge from now
    notes.push_back('{cyc + d + 1, s, e});
  endtask

  // New random inputs; while frozen the expected outputs keep the held values
  task automatic step(bit frz);
    logic [7:0] a, b, c;
    logic [3:0] e;
    a = 8'($random(seed));
    b = 8'($random(seed));
    c = 8'($random(seed));
    e = 4'($random(seed));
    @(posedge clk);
    core_out <= a;
    core_oe  <= b;
    io_r     <= c;
    ded_in   <= e;
    if (!frz) begin
      co = a;
      ce = b;
      dd = e;
      ai = (pin ? (c | pmask) : (c & ~pmask)) & ~m;
      note(1, 7, 8'h2);
    end
    note(1, 0, co);
    note(1, 1, ~ce | m);
    note(1, 2, co);
    note(3, 3, ai);
    note(3, 4, {4'h0, dd});
    note(3, 8, ai);
    note(3, 9, {4'h0, dd});
  endtask

  task automatic run(int n, bit frz);
    repeat (n) step(frz);
  endtask

  task automatic do_reset(logic e, logic s);
    repeat (3) @(posedge clk);
    @(posedge clk);
    rst           <= 1'h1;
    cfg_sleep_en  <= e;
    cfg_sleep_sel <= s;
    req           <= 1'h0;
    note(3, 7, 8'h2);
    note(3, 0, 8'h0);
    note(3, 1, 8'hff);
    note(3, 5, 8'hff);
    note(3, 6, 8'h0f);
    repeat (4) @(posedge clk);
    rst <= 1'h0;
    m = e ? 8'h1 << (s ? SLEEP_PIN_B : SLEEP_PIN_A) : 8'h0;
    repeat (2) @(posedge clk);
  endtask

  task automatic wake(bit redo);
    @(posedge clk);
    req <= 1'h0;
    note(3, 7, 8'h4);
    note(4, 7, 8'h0);
    if (redo) begin
      run(50, 1);
      @(posedge clk);
      req <= 1'h1;
      note(4, 7, 8'h4);
      run(8, 1);
      wake(0);
    end else begin
      note(203, 7, 8'h0);
      note(204, 7, 8'h3);
      note(205, 7, 8'h2);
      run(190, 1);
      for (int i = 0; i < 40 && ready !== 1'h1; i++) @(posedge clk);
      run(6, 0);
    end
  endtask

  task automatic sleep_wake(bit redo);
    run(4, 0);
    @(posedge clk);
    req <= 1'h1;
    note(3, 7, 8'h2);
    note(4, 7, 8'h4);
    note(5, 5, ce | m);
    note(5, 6, 8'h0);
    // Inputs stay valid until the freeze has taken hold
    repeat (3) @(posedge clk);
    run(3, 1);
    run(12, 1);
    wake(redo);
  endtask

  task automatic print_verdict();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    rst           = 1'h1;
    cfg_sleep_en  = 1'h1;
    cfg_sleep_sel = 1'h0;
    req           = 1'h0;
    ded_in        = 4'h0;
    io_r          = 8'h0;
    core_out      = 8'h0;
    core_oe       = 8'h0;
    seed          = 24837;
    do_reset(1'h1, 1'h0);
    run(8, 0);
    sleep_wake(1);
    do_reset(1'h1, 1'h1);
    sleep_wake(0);
    do_reset(1'h0, 1'h0);
    @(posedge clk);
    req <= 1'h1;
    repeat (3) @(posedge clk);
    run(8, 0);
    print_verdict();
  end
endmodule
